/* File: hw/ipq_pkg.sv */
// Shared constants and types of the instruction prefetch queue.
// Assumes a single 100 MHz core clock and an 8-bit memory bus.
package ipq_pkg;

  localparam int ADDR_W = 20;
  localparam int Q_DEPTH = 4;
  localparam int Q_CNT_W = 3;
  localparam logic [Q_CNT_W-1:0] Q_FULL = 3'h4;
  localparam int WAIT_W = 3;
  localparam int N_REGION = 4;
  localparam int REGION_MSB = 19;
  localparam int REGION_LSB = 18;
  localparam int RD_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam logic [ADDR_W-1:0] PC_RESET = 20'h00000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 20'h00001;
  localparam logic [WAIT_W:0] ACC_ONE = 4'h1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CODE = 4'h2,
    ST_DLO = 4'h4,
    ST_DHI = 4'h8
  } ipq_state_type;

  typedef logic [N_REGION-1:0][WAIT_W-1:0] ipq_wait_cfg_type;

  typedef struct packed {
    logic we;
    logic wide;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } ipq_data_cmd_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } ipq_bus_cmd_type;

endpackage

/* File: hw/ipq_fifo.sv */
// Parameterised FIFO that buffers data read results for the core.
// Assumes one clock and an active-low reset already synchronised.
`timescale 1ns/10ps
module ipq_fifo
  import ipq_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
  } ipq_fifo_state_type;

  ipq_fifo_state_type s;
  ipq_fifo_state_type next_s;
  logic do_push;
  logic do_pop;

  assign o_ready = (s.count != (PTR_W + 1)'(DEPTH));
  assign o_valid = (s.count != '0);
  assign o_data = s.mem[s.rd_ptr];
  assign do_push = i_valid && o_ready;
  assign do_pop = o_valid && i_ready;

  always_comb
  begin
    next_s = s;
    if (do_push)
    begin
      next_s.mem[s.wr_ptr] = i_data;
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (do_pop)
    begin
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      next_s.count = s.count + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule

/* File: hw/ipq_top.sv */
// Instruction prefetch queue and bus access sequencer of the core.
// Assumes an 8-bit memory bus that completes a byte in 1 + wait cycles.
`timescale 1ns/10ps
module ipq_top
  import ipq_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [Q_CNT_W-1:0] i_need,
  input wire logic [Q_CNT_W-1:0] i_consume,
  output logic [Q_DEPTH-1:0][7:0] o_code,
  output logic [Q_CNT_W-1:0] o_code_cnt,
  output logic o_code_ok,
  output logic o_stall,
  input wire logic i_flush,
  input wire logic [ADDR_W-1:0] i_new_pc,
  input wire logic i_data_req,
  input wire ipq_data_cmd_type i_data_cmd,
  output logic o_data_gnt,
  output logic o_data_done,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [RD_W-1:0] o_rd_data,
  input wire logic i_bus_avail,
  input wire ipq_wait_cfg_type i_wait_cfg,
  output ipq_bus_cmd_type o_bus,
  input wire logic [7:0] i_bus_rdata
);

  typedef struct packed {
    ipq_state_type st;
    logic [ADDR_W-1:0] fetch_pc;
    logic [Q_DEPTH-1:0][7:0] q;
    logic [Q_CNT_W-1:0] cnt;
    logic drop;
    logic [WAIT_W-1:0] wcnt;
    logic [WAIT_W:0] acc;
    logic [ADDR_W-1:0] addr;
    logic we;
    logic wide;
    logic [15:0] wdata;
    logic [7:0] rd_lo;
    logic [RD_W-1:0] rd;
    logic push;
    logic done;
  } ipq_top_state_type;

  logic [1:0] rst_pipe;
  logic rst_n;
  ipq_top_state_type s;
  ipq_top_state_type next_s;
  logic fifo_ready;
  logic byte_done;
  logic take_data;
  logic take_code;
  logic [Q_CNT_W-1:0] take;
  logic [Q_CNT_W-1:0] left;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_pipe <= 2'b00;
    end
    else
    begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  function automatic logic [WAIT_W-1:0] wait_of(
    input logic [ADDR_W-1:0] addr,
    input ipq_wait_cfg_type cfg
  );
    wait_of = cfg[addr[REGION_MSB:REGION_LSB]];
  endfunction

  // The execution unit sees only queued bytes.
  assign o_code = s.q;
  assign o_code_cnt = s.cnt;
  assign o_code_ok = (s.cnt >= i_need);
  assign o_stall = !o_code_ok;
  assign take = (i_consume <= s.cnt) ? i_consume : '0;
  assign left = s.cnt - take;

  assign byte_done = (s.st != ST_IDLE) && (s.wcnt == '0);
  // A pending push still counts against the buffer until it lands.
  assign take_data = (s.st == ST_IDLE) && i_bus_avail && i_data_req
                     && (i_data_cmd.we || (fifo_ready && !s.push));
  assign take_code = (s.st == ST_IDLE) && i_bus_avail && !take_data
                     && !i_flush && (s.cnt < Q_FULL);
  assign o_data_gnt = take_data;
  assign o_data_done = s.done;

  assign o_bus.req = (s.st != ST_IDLE);
  assign o_bus.we = s.we && (s.st != ST_CODE);
  assign o_bus.addr = s.addr;
  assign o_bus.wdata = (s.st == ST_DHI) ? s.wdata[15:8] : s.wdata[7:0];

  always_comb
  begin
    next_s = s;
    next_s.push = 1'b0;
    next_s.done = 1'b0;
    next_s.cnt = left;
    for (int i = 0; i < Q_DEPTH; i++)
    begin
      if (i + int'(take) < Q_DEPTH)
      begin
        next_s.q[i] = s.q[i + int'(take)];
      end
      else
      begin
        next_s.q[i] = '0;
      end
    end
    if (s.st != ST_IDLE)
    begin
      next_s.acc = s.acc + ACC_ONE;
      if (s.wcnt != '0)
      begin
        next_s.wcnt = s.wcnt - 1'b1;
      end
    end
    case (s.st)
      ST_IDLE:
      begin
        next_s.drop = 1'b0;
        next_s.acc = ACC_ONE;
        if (take_data)
        begin
          next_s.st = ST_DLO;
          next_s.addr = i_data_cmd.addr;
          next_s.we = i_data_cmd.we;
          next_s.wide = i_data_cmd.wide;
          next_s.wdata = i_data_cmd.wdata;
          next_s.wcnt = wait_of(i_data_cmd.addr, i_wait_cfg);
        end
        else if (take_code)
        begin
          next_s.st = ST_CODE;
          next_s.addr = s.fetch_pc;
          next_s.we = 1'b0;
          next_s.wcnt = wait_of(s.fetch_pc, i_wait_cfg);
        end
      end
      ST_CODE:
      begin
        if (byte_done)
        begin
          next_s.st = ST_IDLE;
          if (!s.drop && !i_flush)
          begin
            next_s.q[left[1:0]] = i_bus_rdata;
            next_s.cnt = left + 1'b1;
            next_s.fetch_pc = s.fetch_pc + ADDR_ONE;
          end
        end
      end
      ST_DLO:
      begin
        if (byte_done)
        begin
          next_s.rd_lo = i_bus_rdata;
          if (s.wide)
          begin
            // The high byte is a second full byte access.
            next_s.st = ST_DHI;
            next_s.addr = s.addr + ADDR_ONE;
            next_s.wcnt = wait_of(s.addr + ADDR_ONE, i_wait_cfg);
            next_s.acc = ACC_ONE;
          end
          else
          begin
            next_s.st = ST_IDLE;
            next_s.done = 1'b1;
            next_s.push = !s.we;
            next_s.rd = {8'h00, i_bus_rdata};
          end
        end
      end
      ST_DHI:
      begin
        if (byte_done)
        begin
          next_s.st = ST_IDLE;
          next_s.done = 1'b1;
          next_s.push = !s.we;
          next_s.rd = {i_bus_rdata, s.rd_lo};
        end
      end
      default:
      begin
        next_s.st = ST_IDLE;
      end
    endcase
    if (i_flush)
    begin
      next_s.cnt = '0;
      next_s.q = '0;
      next_s.fetch_pc = i_new_pc;
      next_s.drop = (s.st == ST_CODE);
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.fetch_pc <= PC_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  ipq_fifo #(
    .WIDTH(RD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_valid(s.push),
    .o_ready(fifo_ready),
    .i_data(s.rd),
    .o_valid(o_rd_valid),
    .i_ready(i_rd_ready),
    .o_data(o_rd_data)
  );

  // Checks of the sequencer against its timing and ordering.
  a_queue_bound: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    s.cnt <= Q_FULL)
    else $error("queue count above four");

  a_fetch_free: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s.st == ST_IDLE && i_bus_avail && !i_data_req && !i_flush
     && s.cnt < Q_FULL) |=> (s.st == ST_CODE))
    else $error("free queue did not start a fetch");

  a_stall_short: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (o_stall && s.st == ST_IDLE && i_bus_avail && !i_data_req && !i_flush
     && i_need <= Q_FULL) |=> (s.st == ST_CODE))
    else $error("stall did not keep code reads going");

  a_code_wait: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s.st == ST_CODE && byte_done)
    |-> (s.acc == {1'b0, wait_of(s.addr, i_wait_cfg)} + ACC_ONE))
    else $error("code read length differs from wait count");

  a_data_wait: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    ((s.st == ST_DLO || s.st == ST_DHI) && byte_done)
    |-> (s.acc == {1'b0, wait_of(s.addr, i_wait_cfg)} + ACC_ONE))
    else $error("data access length differs from wait count");

  a_wide_split: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s.st == ST_DLO && byte_done && s.wide)
    |=> (s.st == ST_DHI && s.addr == $past(s.addr) + ADDR_ONE))
    else $error("wide transfer not split into two bytes");

  a_data_first: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s.st == ST_IDLE && i_bus_avail && i_data_req && i_data_cmd.we)
    |-> (o_data_gnt && !take_code) ##1 (s.st == ST_DLO))
    else $error("prefetch won over data access");

  a_full_idle: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (s.st == ST_IDLE && s.cnt == Q_FULL && !i_data_req)
    |=> (s.st == ST_IDLE))
    else $error("fetch issued with full queue");

  a_base_byte: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    (o_data_gnt && !i_data_cmd.wide
     && wait_of(i_data_cmd.addr, i_wait_cfg) == '0)
    |-> ##2 o_data_done)
    else $error("zero-wait byte access not done in two cycles");

  a_flush_empty: assert property (
    @(posedge i_ref_clk) disable iff (!rst_n)
    i_flush |=> (s.cnt == '0 && s.fetch_pc == $past(i_new_pc)))
    else $error("flush did not empty the queue");

  c_wide_read: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    s.st == ST_DHI && byte_done && !s.we);
  c_queue_full: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    s.cnt == Q_FULL);
  c_flush_fetch: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    i_flush && s.st == ST_CODE);
  c_fifo_full: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
    i_data_req && !i_data_cmd.we && !fifo_ready);

endmodule

/* File: verif/ipq_mem_model.sv */
// Bus partner model: memory answering byte reads.
// Assumes the core holds o_bus stable for each whole byte access.
`timescale 1ns/10ps
module ipq_mem_model
  import ipq_pkg::*;
(
  input wire logic i_ref_clk,
  input wire ipq_bus_cmd_type i_bus,
  output logic [7:0] o_rdata
);
  logic [7:0] last = 8'h00;

  // Off a read the lines show the inverse of the last byte, never a hold.
  always_comb
  begin
    if (i_bus.req && !i_bus.we)
      o_rdata = i_bus.addr[7:0] ^ i_bus.addr[19:12] ^ 8'h5A;
    else
      o_rdata = ~last;
  end

  always @(posedge i_ref_clk)
    last <= o_rdata;
endmodule

/* File: verif/ipq_top_tb_top.sv */
// Self-checking bench of the prefetch queue against a queue model.
// Assumes the bus partner model and a 100 MHz clock.
`timescale 1ns/10ps
module ipq_top_tb_top
  import ipq_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [Q_CNT_W-1:0] need = 3'h0;
  logic [Q_CNT_W-1:0] consume = 3'h0;
  logic [Q_DEPTH-1:0][7:0] code;
  logic [Q_CNT_W-1:0] code_cnt;
  logic code_ok;
  logic stall;
  logic flush = 1'b0;
  logic [ADDR_W-1:0] new_pc = 20'h00000;
  logic data_req = 1'b0;
  ipq_data_cmd_type data_cmd = '0;
  logic gnt;
  logic done;
  logic rd_valid;
  logic rd_ready = 1'b1;
  logic [RD_W-1:0] rd_data;
  logic bus_avail = 1'b1;
  ipq_wait_cfg_type wait_cfg = {3'h3, 3'h0, 3'h5, 3'h1};
  ipq_bus_cmd_type bus;
  logic [7:0] rdata;
  logic rnd_on = 1'b0;
  logic hold_rd = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'he0cd4e5d;
  int pc_exp = 0;
  int seg_len = 0;
  logic [ADDR_W-1:0] seg_addr = 20'h00000;
  logic [RD_W-1:0] rdq[$];

  always #5 clk = ~clk;

  ipq_top dut (
    .i_ref_clk(clk),
    .i_arst_n(arst_n),
    .i_need(need),
    .i_consume(consume),
    .o_code(code),
    .o_code_cnt(code_cnt),
    .o_code_ok(code_ok),
    .o_stall(stall),
    .i_flush(flush),
    .i_new_pc(new_pc),
    .i_data_req(data_req),
    .i_data_cmd(data_cmd),
    .o_data_gnt(gnt),
    .o_data_done(done),
    .o_rd_valid(rd_valid),
    .i_rd_ready(rd_ready),
    .o_rd_data(rd_data),
    .i_bus_avail(bus_avail),
    .i_wait_cfg(wait_cfg),
    .o_bus(bus),
    .i_bus_rdata(rdata)
  );

  ipq_mem_model mem (.i_ref_clk(clk), .i_bus(bus), .o_rdata(rdata));

  function automatic logic [7:0] memv(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ a[19:12] ^ 8'h5A;
  endfunction

  function automatic int wt(input logic [ADDR_W-1:0] a);
    return int'(wait_cfg[a[REGION_MSB:REGION_LSB]]);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One data access; timing is counted from the grant cycle.
  task automatic dacc(input logic we, input logic wide,
                      input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    @(posedge clk);
    data_req <= 1'b1;
    data_cmd <= {we, wide, a, 16'(~a)};
    @(negedge clk);
    while (gnt !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    chk(gnt, 1'b1);
    if (!we)
      rdq.push_back({wide ? memv(a + 20'h1) : 8'h00, memv(a)});
    @(posedge clk);
    data_req <= 1'b0;
    for (n = 1; n < 40; n++)
    begin
      @(negedge clk);
      if (n == 1)
        chk({bus.req, bus.we, bus.addr}, {1'b1, we, a});
      if (n == 1 && we)
        chk(bus.wdata, 8'(~a[7:0]));
      if (wide && n == 2 + wt(a))
        chk({bus.req, bus.addr}, {1'b1, a + 20'h1});
      if (wide && we && n == 2 + wt(a))
        chk(bus.wdata, 8'(~a[15:8]));
      if (done === 1'b1)
        break;
    end
    chk(n, wide ? 3 + wt(a) + wt(a + 20'h1) : 2 + wt(a));
  endtask

  always @(posedge clk)
    if (rnd_on)
    begin
      need <= 3'({$random(seed)} % 5);
      consume <= 3'($random(seed));
      flush <= ({$random(seed)} % 12 == 0);
      new_pc <= 20'($random(seed));
      bus_avail <= ({$random(seed)} % 4 != 0);
      rd_ready <= !hold_rd && $random(seed) % 2 == 0;
    end

  // Queue model: expected oldest address advances on accepted consumes.
  always @(negedge clk)
    if (!arst_n)
    begin
      pc_exp = 0;
      seg_len = 0;
    end
    else
    begin
      for (int i = 0; i < Q_DEPTH; i++)
        chk(code[i], i < code_cnt ? memv(20'(pc_exp + i)) : 8'h00);
      chk({code_ok, stall}, {code_cnt >= need, code_cnt < need});
      if (seg_len > 0 && (!bus.req || bus.addr != seg_addr))
      begin
        chk(seg_len, 1 + wt(seg_addr));
        seg_len = 0;
      end
      if (bus.req)
      begin
        seg_addr = bus.addr;
        seg_len++;
      end
      if (rd_valid && rd_ready)
        chk(rd_data, rdq.size() > 0 ? rdq.pop_front() : 'x);
      if (flush)
        pc_exp = new_pc;
      else if (consume <= code_cnt)
        pc_exp += consume;
    end

  initial
  begin
    #900000;
    err_total++;
    end_of_test();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 200 && code_cnt !== Q_FULL; i++)
      @(negedge clk);
    repeat (8)
    begin
      @(negedge clk);
      chk({code_cnt, bus.req}, {Q_FULL, 1'b0});
    end
    @(posedge clk);
    rnd_on <= 1'b1;
    repeat (60)
      dacc(1'($random(seed)), 1'($random(seed)), 20'($random(seed)));
    for (int i = 0; i < 900 && rdq.size() != 0; i++)
      @(negedge clk);
    hold_rd = 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++)
      dacc(1'b0, 1'b0, 20'(i));
    fork
      dacc(1'b0, 1'b1, 20'h3FFFF);
      begin
        repeat (20)
        begin
          @(negedge clk);
          chk(gnt, 1'b0);
        end
        hold_rd = 1'b0;
      end
    join
    for (int i = 0; i < 900 && rdq.size() != 0; i++)
      @(negedge clk);
    chk(rdq.size(), 0);
    end_of_test();
  end
endmodule
